//--- design/icf_irq_flags.sv
`timescale 1ns/1ps
// How it works
// - pull-up disable bit set turns all port-B pull-ups off, else latch decides
// - four edge-select bits: 1 rising edge, 0 falling edge
// - timer0, ext3 and port-change priority bits: 1 high, 0 low
// - top two bits of control three give ext2 and ext1 priority
// - bits 5..3 enable external interrupts 3, 2, 1
// - bits 2..0 flag external interrupts 3, 2, 1 until software clears
// - flags set on events regardless of any enable
// - converter-done flag sets on conversion end, held until cleared
// - receive-full flag read-only, mirrors full buffer, cleared by buffer read
// - transmit-empty flag read-only, mirrors empty buffer, cleared by buffer write
// - sync serial flag sets on transfer completion, held until cleared
// - timer2 period match flag sets on match, held until cleared
// - timer1 overflow flag sets on overflow, held until cleared
// - unimplemented flag bits read zero
// - oscillator-fail flag sets on clock fail, cleared only by software
// - comparator flag sets on input change, held until cleared
// - bus-collision flag sets on collision, held until cleared
// - low-voltage flag sets on detection, held until cleared
// - timer3 overflow flag sets on overflow, held until cleared
// - priority disabled: per-source priority bits ignored
// - request vectors to 08h or 18h when flag, enable, global enable set
// - priority disabled: peripheral requests need peripheral global enable
module icf_irq_flags (
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [2:0]          reg_addr_in,
  input  wire logic [7:0]          reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [7:0]          reg_rdata_out,
  input  wire logic [3:0]          ext_irq_pin_in,
  input  wire logic [7:0]          port_b_latch_in,
  output logic      [7:0]          port_b_pullup_en_out,
  input  wire icf_pkg::icf_events_s periph_evt_in,
  input  wire logic                serial1_rx_full_in,
  input  wire logic                serial1_tx_empty_in,
  input  wire logic                timer0_flag_in,
  input  wire logic                timer0_en_in,
  input  wire logic                port_change_flag_in,
  input  wire logic                port_change_en_in,
  output logic      [3:0]          ext_irq_edge_out,
  output icf_pkg::icf_irq_s        irq_out
);

  logic [7:0] ctrl_two_q;
  logic [7:0] ctrl_three_q;
  logic [7:0] pflags_one_q;
  logic [7:0] pflags_two_q;
  logic [7:0] core_ctrl_q;
  logic [7:0] enables_q;
  logic [7:0] prios_q;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [3:0] pin_prev_q;
  logic [3:0] edge_sel;
  logic [3:0] edge_hit;
  logic       wr_ct2;
  logic       wr_ct3;
  logic       wr_pf1;
  logic       wr_pf2;
  logic [7:0] rdata_d;
  logic [7:0] pf1_view;
  logic       prio_en;
  logic       any_high;
  logic       any_low;
  logic       ext1_hi;
  logic       ext2_hi;
  logic       ext3_hi;
  logic       t0_hi;
  logic       pc_hi;
  logic [7:0] pf1_act;
  logic [7:0] pf2_act;
  logic [7:0] pf1_set;
  logic [7:0] pf2_set;
  logic [7:0] sw_wdata;

  // write strobes per register
  always_comb begin
    wr_ct2 = reg_wr_in && (reg_addr_in == icf_pkg::ADDR_CTRL_TWO);
    wr_ct3 = reg_wr_in && (reg_addr_in == icf_pkg::ADDR_CTRL_THREE);
    wr_pf1 = reg_wr_in && (reg_addr_in == icf_pkg::ADDR_PFLAGS_ONE);
    wr_pf2 = reg_wr_in && (reg_addr_in == icf_pkg::ADDR_PFLAGS_TWO);
    sw_wdata = reg_wdata_in;
  end

  // pins are asynchronous: two flops, then a third for edge compare
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else begin
      pin_meta_q <= ext_irq_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // edge select bits 6..3 map to pins 0..3
  always_comb begin
    edge_sel = {ctrl_two_q[icf_pkg::CT2_EDGE3], ctrl_two_q[icf_pkg::CT2_EDGE3 + 1],
                ctrl_two_q[icf_pkg::CT2_EDGE3 + 2], ctrl_two_q[icf_pkg::CT2_EDGE0]};
    for (int i = 0; i < 4; i++) begin
      edge_hit[i] = edge_sel[i] ? (pin_sync_q[i] && !pin_prev_q[i])
                                : (!pin_sync_q[i] && pin_prev_q[i]);
    end
  end

  // control two: fully software owned
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_two_q <= icf_pkg::RST_CTRL_TWO;
    end else if (wr_ct2) begin
      ctrl_two_q <= reg_wdata_in;
    end
  end

  // control three: flags set by pin edges; a set beats a same-cycle clear
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_three_q <= icf_pkg::RST_CTRL_THREE;
    end else begin
      if (wr_ct3) begin
        ctrl_three_q <= reg_wdata_in;
      end
      for (int i = 1; i < 4; i++) begin
        if (edge_hit[i]) begin
          ctrl_three_q[icf_pkg::CT3_FLAG_LO + i - 1] <= 1'b1;
        end
      end
    end
  end

  // hardware-set peripheral flags; held until software writes a zero
  always_comb begin
    pf1_set = 8'h00;
    pf1_set[icf_pkg::PF1_ADC]  = periph_evt_in.adc_done;
    pf1_set[icf_pkg::PF1_SSP]  = periph_evt_in.sync_serial_done;
    pf1_set[icf_pkg::PF1_TMR2] = periph_evt_in.timer2_match;
    pf1_set[icf_pkg::PF1_TMR1] = periph_evt_in.timer1_ovf;
    pf2_set = 8'h00;
    pf2_set[icf_pkg::PF2_OSC]  = periph_evt_in.osc_fail;
    pf2_set[icf_pkg::PF2_CMP]  = periph_evt_in.comparator_change;
    pf2_set[icf_pkg::PF2_BCL]  = periph_evt_in.bus_collision;
    pf2_set[icf_pkg::PF2_LVD]  = periph_evt_in.low_voltage;
    pf2_set[icf_pkg::PF2_TMR3] = periph_evt_in.timer3_ovf;
  end

  // flag register one, storage for software-clearable bits only
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pflags_one_q <= icf_pkg::RST_FLAGS;
    end else if (wr_pf1) begin
      pflags_one_q <= ((sw_wdata & icf_pkg::PF1_SW_MASK) | pf1_set) & icf_pkg::PF1_SW_MASK;
    end else begin
      pflags_one_q <= (pflags_one_q | pf1_set) & icf_pkg::PF1_SW_MASK;
    end
  end

  // flag register two
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pflags_two_q <= icf_pkg::RST_FLAGS;
    end else if (wr_pf2) begin
      pflags_two_q <= (sw_wdata | pf2_set) & icf_pkg::PF2_MASK;
    end else begin
      pflags_two_q <= (pflags_two_q | pf2_set) & icf_pkg::PF2_MASK;
    end
  end

  // serial flags follow the buffers; the port clears them on buffer access
  always_comb begin
    pf1_view = pflags_one_q;
    pf1_view[icf_pkg::PF1_RX] = serial1_rx_full_in;
    pf1_view[icf_pkg::PF1_TX] = serial1_tx_empty_in;
    pf1_view = pf1_view & icf_pkg::PF1_MASK;
  end

  // extra control: priority enable, peripheral and global enables
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      core_ctrl_q <= icf_pkg::RST_CORE_CTRL;
      enables_q   <= icf_pkg::RST_ENABLES;
      prios_q     <= icf_pkg::RST_PRIOS;
    end else if (reg_wr_in) begin
      if (reg_addr_in == icf_pkg::ADDR_CORE_CTRL) begin
        core_ctrl_q <= reg_wdata_in & 8'h07;
      end else if (reg_addr_in == icf_pkg::ADDR_ENABLES) begin
        enables_q <= reg_wdata_in;
      end else if (reg_addr_in == icf_pkg::ADDR_PRIOS) begin
        prios_q <= reg_wdata_in;
      end
    end
  end

  // read mux, data one cycle after the strobe; unmapped reads zero
  always_comb begin
    if (reg_addr_in == icf_pkg::ADDR_CTRL_TWO) begin
      rdata_d = ctrl_two_q;
    end else if (reg_addr_in == icf_pkg::ADDR_CTRL_THREE) begin
      rdata_d = ctrl_three_q;
    end else if (reg_addr_in == icf_pkg::ADDR_PFLAGS_ONE) begin
      rdata_d = pf1_view;
    end else if (reg_addr_in == icf_pkg::ADDR_PFLAGS_TWO) begin
      rdata_d = pflags_two_q;
    end else if (reg_addr_in == icf_pkg::ADDR_CORE_CTRL) begin
      rdata_d = core_ctrl_q;
    end else if (reg_addr_in == icf_pkg::ADDR_ENABLES) begin
      rdata_d = enables_q;
    end else if (reg_addr_in == icf_pkg::ADDR_PRIOS) begin
      rdata_d = prios_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // pull-ups registered so the pad sees a clean level
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      port_b_pullup_en_out <= 8'h00;
    end else if (ctrl_two_q[icf_pkg::CT2_PULLUP_DIS]) begin
      port_b_pullup_en_out <= 8'h00;
    end else begin
      port_b_pullup_en_out <= port_b_latch_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ext_irq_edge_out <= 4'h0;
    end else begin
      ext_irq_edge_out <= edge_hit;
    end
  end

  // request evaluation; enables register gates flags one bit for bit, flags two have no per-source enables
  always_comb begin
    prio_en = core_ctrl_q[icf_pkg::CC_PRIO_EN];
    pf1_act = pf1_view & enables_q & icf_pkg::PF1_MASK;
    pf2_act = pflags_two_q & prios_q & 8'h00;
    pf2_act = pflags_two_q & icf_pkg::PF2_MASK & {8{core_ctrl_q[icf_pkg::CC_PERIPH_EN]}};
    // priority bits count only with priority enabled
    ext1_hi = prio_en && ctrl_three_q[icf_pkg::CT3_EXT1_PRIO];
    ext2_hi = prio_en && ctrl_three_q[icf_pkg::CT3_EXT2_PRIO];
    ext3_hi = prio_en && ctrl_two_q[icf_pkg::CT2_EXT3_PRIO];
    t0_hi   = prio_en && ctrl_two_q[icf_pkg::CT2_TMR0_PRIO];
    pc_hi   = prio_en && ctrl_two_q[icf_pkg::CT2_PORT_PRIO];
    any_high = 1'b0;
    any_low  = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (ctrl_three_q[icf_pkg::CT3_FLAG_LO + i] && ctrl_three_q[icf_pkg::CT3_EN_LO + i]) begin
        if ((i == 0 && ext1_hi) || (i == 1 && ext2_hi) || (i == 2 && ext3_hi)) begin
          any_high = 1'b1;
        end else begin
          any_low = 1'b1;
        end
      end
    end
    if (timer0_flag_in && timer0_en_in) begin
      if (t0_hi) any_high = 1'b1;
      else any_low = 1'b1;
    end
    if (port_change_flag_in && port_change_en_in) begin
      if (pc_hi) any_high = 1'b1;
      else any_low = 1'b1;
    end
    // peripheral sources: low priority in priority mode, gated otherwise
    if (prio_en) begin
      if (|pf1_act || |(pflags_two_q & icf_pkg::PF2_MASK)) any_low = 1'b1;
    end else if (core_ctrl_q[icf_pkg::CC_PERIPH_EN]) begin
      if (|pf1_act || |pf2_act) any_low = 1'b1;
    end
  end

  // global enable gates the request; compatibility mode always uses 08h
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_out <= '0;
    end else begin
      irq_out.req  <= core_ctrl_q[icf_pkg::CC_GLOBAL_EN] && (any_high || any_low);
      irq_out.high <= any_high || !prio_en;
      irq_out.vector <= (any_high || !prio_en) ? icf_pkg::VEC_HIGH
                                                : icf_pkg::VEC_LOW;
    end
  end

endmodule

//--- design/icf_pkg.sv
package icf_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL_TWO   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_THREE = 3'h1;
  localparam logic [2:0] ADDR_PFLAGS_ONE = 3'h2;
  localparam logic [2:0] ADDR_PFLAGS_TWO = 3'h3;
  localparam logic [2:0] ADDR_CORE_CTRL  = 3'h4;
  localparam logic [2:0] ADDR_ENABLES    = 3'h5;
  localparam logic [2:0] ADDR_PRIOS      = 3'h6;

  // values after reset
  localparam logic [7:0] RST_CTRL_TWO    = 8'hff;
  localparam logic [7:0] RST_CTRL_THREE  = 8'hc0;
  localparam logic [7:0] RST_FLAGS       = 8'h00;
  localparam logic [7:0] RST_CORE_CTRL   = 8'h00;
  localparam logic [7:0] RST_ENABLES     = 8'h00;
  localparam logic [7:0] RST_PRIOS       = 8'hff;

  // implemented bits of the flag registers
  localparam logic [7:0] PF1_MASK        = 8'h7b;
  localparam logic [7:0] PF2_MASK        = 8'hce;
  // flags that software may write (clear); hardware-held flags excluded
  localparam logic [7:0] PF1_SW_MASK     = 8'h4b;

  // control two field positions
  localparam int CT2_PULLUP_DIS = 7;
  localparam int CT2_EDGE0      = 6;
  localparam int CT2_EDGE3      = 3;
  localparam int CT2_TMR0_PRIO  = 2;
  localparam int CT2_EXT3_PRIO  = 1;
  localparam int CT2_PORT_PRIO  = 0;
  // control three field positions
  localparam int CT3_EXT2_PRIO  = 7;
  localparam int CT3_EXT1_PRIO  = 6;
  localparam int CT3_EN_LO      = 3;
  localparam int CT3_FLAG_LO    = 0;
  // flag positions
  localparam int PF1_ADC        = 6;
  localparam int PF1_RX         = 5;
  localparam int PF1_TX         = 4;
  localparam int PF1_SSP        = 3;
  localparam int PF1_TMR2       = 1;
  localparam int PF1_TMR1       = 0;
  localparam int PF2_OSC        = 7;
  localparam int PF2_CMP        = 6;
  localparam int PF2_BCL        = 3;
  localparam int PF2_LVD        = 2;
  localparam int PF2_TMR3       = 1;
  // core control positions
  localparam int CC_PRIO_EN     = 2;
  localparam int CC_PERIPH_EN   = 1;
  localparam int CC_GLOBAL_EN   = 0;

  localparam logic [7:0] VEC_HIGH = 8'h08;
  localparam logic [7:0] VEC_LOW  = 8'h18;

  // one-cycle events from the on-chip peripherals
  typedef struct packed {
    logic adc_done;
    logic sync_serial_done;
    logic timer2_match;
    logic timer1_ovf;
    logic osc_fail;
    logic comparator_change;
    logic bus_collision;
    logic low_voltage;
    logic timer3_ovf;
  } icf_events_s;

  // request to the core
  typedef struct packed {
    logic       req;
    logic       high;
    logic [7:0] vector;
  } icf_irq_s;

endpackage

//--- test/icf_irq_flags_chk.sv
`timescale 1ns/1ps
module icf_irq_flags_chk (
  input wire logic                 core_clk_in,
  input wire logic                 rst_n_in,
  input wire logic [2:0]           reg_addr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic [3:0]           ext_irq_pin_in,
  input wire logic [7:0]           port_b_latch_in,
  input wire logic [7:0]           port_b_pullup_en_out,
  input wire icf_pkg::icf_events_s periph_evt_in,
  input wire logic                 serial1_rx_full_in,
  input wire logic                 serial1_tx_empty_in,
  input wire logic [3:0]           ext_irq_edge_out,
  input wire icf_pkg::icf_irq_s    irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // flag bit of each event, timer3 first; indices below 5 live in flags two
  localparam int EV_BIT [9] = '{1, 2, 3, 6, 7, 0, 1, 3, 6};
  logic [7:0] ct2_q;
  logic [7:0] cc_q;
  logic [8:0] evt_v;
  assign evt_v = periph_evt_in;
  // shadows of edge select and core control, taken from the write strobe
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ct2_q <= icf_pkg::RST_CTRL_TWO;
      cc_q  <= icf_pkg::RST_CORE_CTRL;
    end else if (reg_wr_in && reg_addr_in == icf_pkg::ADDR_CTRL_TWO) begin
      ct2_q <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == icf_pkg::ADDR_CORE_CTRL) begin
      cc_q <= reg_wdata_in;
    end
  end
  sequence s_rd(logic [2:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence s_wr_ct2;
    reg_wr_in && reg_addr_in == icf_pkg::ADDR_CTRL_TWO;
  endsequence
  property p_pullup_off;
    s_wr_ct2 ##0 reg_wdata_in[7] |=> ##1 port_b_pullup_en_out == 8'h00;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-ups on while disabled");
  property p_pullup_on;
    s_wr_ct2 ##0 !reg_wdata_in[7] ##1 !reg_wr_in && $stable(port_b_latch_in)
      |=> port_b_pullup_en_out == port_b_latch_in;
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pull-ups ignore latch");
  property p_unimpl_one;
    s_rd(icf_pkg::ADDR_PFLAGS_ONE) |=> (reg_rdata_out & ~icf_pkg::PF1_MASK) == 8'h00;
  endproperty
  a_unimpl_one: assert property (p_unimpl_one) else $error("flags one spare bit set");
  property p_unimpl_two;
    s_rd(icf_pkg::ADDR_PFLAGS_TWO) |=> (reg_rdata_out & ~icf_pkg::PF2_MASK) == 8'h00;
  endproperty
  a_unimpl_two: assert property (p_unimpl_two) else $error("flags two spare bit set");
  property p_rx_full;
    s_rd(icf_pkg::ADDR_PFLAGS_ONE) ##0 $stable(serial1_rx_full_in)
      |=> reg_rdata_out[5] == $past(serial1_rx_full_in);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive-full flag wrong");
  property p_tx_empty;
    s_rd(icf_pkg::ADDR_PFLAGS_ONE) ##0 $stable(serial1_tx_empty_in)
      |=> reg_rdata_out[4] == $past(serial1_tx_empty_in);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("transmit-empty flag wrong");
  // a pulse must be readable in a read one cycle after it, even beside a clear
  property p_evt_flag(int i);
    evt_v[i] ##1 s_rd(i < 5 ? icf_pkg::ADDR_PFLAGS_TWO : icf_pkg::ADDR_PFLAGS_ONE)
      |=> reg_rdata_out[EV_BIT[i]];
  endproperty
  // the pin must have sat at the selected level two cycles before its edge is reported
  property p_edge(int i);
    ext_irq_edge_out[i] |-> $past(ext_irq_pin_in[i], 2) == ct2_q[6 - i];
  endproperty
  for (genvar i = 0; i < 9; i++) begin : g_evt
    a_evt_flag: assert property (p_evt_flag(i)) else $error("event flag missed");
  end
  for (genvar i = 0; i < 4; i++) begin : g_edge
    a_edge: assert property (p_edge(i)) else $error("edge of wrong sense");
  end
  property p_compat;
    irq_out.req && !$past(cc_q[icf_pkg::CC_PRIO_EN]) |-> irq_out.vector == icf_pkg::VEC_HIGH;
  endproperty
  a_compat: assert property (p_compat) else $error("compat request not at 08h");
  property p_gie;
    !$past(cc_q[icf_pkg::CC_GLOBAL_EN]) && !$past(cc_q[icf_pkg::CC_PRIO_EN]) |-> !irq_out.req;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_vec;
    irq_out.req && $past(cc_q[icf_pkg::CC_PRIO_EN])
      |-> irq_out.vector == (irq_out.high ? icf_pkg::VEC_HIGH : icf_pkg::VEC_LOW);
  endproperty
  a_vec: assert property (p_vec) else $error("vector does not match priority");
endmodule

bind icf_irq_flags icf_irq_flags_chk u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .ext_irq_pin_in(ext_irq_pin_in),
  .port_b_latch_in(port_b_latch_in), .port_b_pullup_en_out(port_b_pullup_en_out),
  .periph_evt_in(periph_evt_in), .serial1_rx_full_in(serial1_rx_full_in),
  .serial1_tx_empty_in(serial1_tx_empty_in), .ext_irq_edge_out(ext_irq_edge_out),
  .irq_out(irq_out)
);

//--- test/icf_far_model.sv
`timescale 1ns/1ps
// peripheral event sources and the serial port's buffer levels
module icf_far_model (
  input  wire logic            core_clk_in,
  output icf_pkg::icf_events_s evt_out,
  output logic                 rx_full_out,
  output logic                 tx_empty_out
);
  initial begin
    evt_out = '0;
    rx_full_out = 1'b0;
    tx_empty_out = 1'b0;
  end
  // events last one cycle; a held line would count as a stream of events
  always @(posedge core_clk_in) begin
    if (evt_out != '0) begin
      evt_out <= '0;
    end
  end
  task automatic pulse(input logic [8:0] m);
    @(posedge core_clk_in);
    evt_out <= m;
  endtask
  task automatic set_lvl(input logic rx, input logic tx);
    @(posedge core_clk_in);
    rx_full_out <= rx;
    tx_empty_out <= tx;
  endtask
endmodule

//--- test/icf_irq_flags_tb.sv
`timescale 1ns/1ps
module icf_irq_flags_tb;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] rd;
    logic [7:0] pu;
  } icf_row_s;
  localparam icf_row_s ROWS [12] = '{
    '{3'h0, 8'h7f, 8'h7f, 8'ha5}, '{3'h0, 8'hff, 8'hff, 8'h00},
    '{3'h1, 8'h38, 8'h38, 8'h00}, '{3'h1, 8'hc0, 8'hc0, 8'h00},
    '{3'h2, 8'hff, 8'h4b, 8'h00}, '{3'h2, 8'h00, 8'h00, 8'h00},
    '{3'h3, 8'hff, 8'hce, 8'h00}, '{3'h3, 8'h00, 8'h00, 8'h00},
    '{3'h4, 8'h07, 8'h07, 8'h00}, '{3'h4, 8'h00, 8'h00, 8'h00},
    '{3'h6, 8'h5a, 8'h5a, 8'h00}, '{3'h7, 8'hff, 8'h00, 8'h00}};
  localparam int EV_B [9] = '{1, 2, 3, 6, 7, 0, 1, 3, 6};
  localparam logic [7:0] RV [8] = '{8'hff, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [2:0]           addr = 3'h0;
  logic [7:0]           wdata = 8'h00;
  logic                 wr_s = 1'b0;
  logic                 rd_s = 1'b0;
  logic [3:0]           pins = 4'h0;
  logic [7:0]           latch = 8'ha5;
  logic                 t0 = 1'b0;
  logic                 pc = 1'b0;
  logic [7:0]           rdata;
  logic [7:0]           pu;
  logic [3:0]           edg;
  logic [7:0]           v;
  icf_pkg::icf_events_s evt;
  icf_pkg::icf_irq_s    irq;
  logic                 rx;
  logic                 tx;
  int                   n_mismatch = 0;
  int                   compares = 0;
  always #4 clk = ~clk;
  icf_irq_flags u_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .ext_irq_pin_in(pins),
    .port_b_latch_in(latch), .port_b_pullup_en_out(pu), .periph_evt_in(evt),
    .serial1_rx_full_in(rx), .serial1_tx_empty_in(tx), .timer0_flag_in(t0),
    .timer0_en_in(t0), .port_change_flag_in(pc), .port_change_en_in(pc),
    .ext_irq_edge_out(edg), .irq_out(irq));
  icf_far_model u_far (.core_clk_in(clk), .evt_out(evt), .rx_full_out(rx), .tx_empty_out(tx));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request reads as its vector, or zero when absent
  task automatic chk_irq(input logic [7:0] e);
    repeat (2) @(posedge clk);
    #1 cmp(irq.req ? irq.vector : 8'h00, e);
  endtask
  task automatic ext(input logic [3:0] p, input logic [7:0] e);
    logic [7:0] x;
    @(posedge clk);
    pins <= p;
    repeat (6) @(posedge clk);
    rd(icf_pkg::ADDR_CTRL_THREE, x);
    cmp(x, e);
    wr(icf_pkg::ADDR_CTRL_THREE, 8'hc0);
  endtask
  task automatic final_report;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog sized well above the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      cmp(v, ROWS[i].rd);
      cmp(pu, ROWS[i].pu);
    end
    // every event with all enables off, read at once, then cleared
    for (int i = 0; i < 9; i++) begin
      u_far.pulse(9'h001 << i);
      rd(i < 5 ? icf_pkg::ADDR_PFLAGS_TWO : icf_pkg::ADDR_PFLAGS_ONE, v);
      cmp(v & (8'h01 << EV_B[i]), 8'h01 << EV_B[i]);
      wr(i < 5 ? icf_pkg::ADDR_PFLAGS_TWO : icf_pkg::ADDR_PFLAGS_ONE, 8'h00);
    end
    // a clear in the same cycle as the event loses
    fork
      u_far.pulse(9'h100);
      wr(icf_pkg::ADDR_PFLAGS_ONE, 8'h00);
    join
    rd(icf_pkg::ADDR_PFLAGS_ONE, v);
    cmp(v, 8'h40);
    wr(icf_pkg::ADDR_PFLAGS_ONE, 8'h00);
    u_far.set_lvl(1'b1, 1'b1);
    wr(icf_pkg::ADDR_PFLAGS_ONE, 8'h00);
    rd(icf_pkg::ADDR_PFLAGS_ONE, v);
    cmp(v, 8'h30);
    u_far.set_lvl(1'b0, 1'b1);
    rd(icf_pkg::ADDR_PFLAGS_ONE, v);
    cmp(v, 8'h10);
    u_far.set_lvl(1'b0, 1'b0);
    ext(4'hf, 8'hc7);
    wr(icf_pkg::ADDR_CTRL_TWO, 8'h87);
    ext(4'h0, 8'hc7);
    ext(4'hf, 8'hc0);
    wr(icf_pkg::ADDR_CTRL_TWO, 8'hff);
    ext(4'h0, 8'hc0);
    @(posedge clk);
    t0 <= 1'b1;
    wr(icf_pkg::ADDR_CTRL_TWO, 8'hfb);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h07);
    chk_irq(icf_pkg::VEC_LOW);
    wr(icf_pkg::ADDR_CTRL_TWO, 8'hff);
    chk_irq(icf_pkg::VEC_HIGH);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h00);
    t0 <= 1'b0;
    // port-change source: its own priority bit picks the vector
    pc <= 1'b1;
    wr(icf_pkg::ADDR_CTRL_TWO, 8'hfe);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h07);
    chk_irq(icf_pkg::VEC_LOW);
    wr(icf_pkg::ADDR_CTRL_TWO, 8'hff);
    chk_irq(icf_pkg::VEC_HIGH);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h00);
    pc <= 1'b0;
    wr(icf_pkg::ADDR_CTRL_THREE, 8'hc9);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h01);
    chk_irq(icf_pkg::VEC_HIGH);
    wr(icf_pkg::ADDR_CTRL_THREE, 8'hc1);
    chk_irq(8'h00);
    wr(icf_pkg::ADDR_CTRL_THREE, 8'h89);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h07);
    chk_irq(icf_pkg::VEC_LOW);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h03);
    chk_irq(icf_pkg::VEC_HIGH);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h02);
    chk_irq(8'h00);
    wr(icf_pkg::ADDR_CTRL_THREE, 8'hc0);
    wr(icf_pkg::ADDR_ENABLES, 8'h40);
    u_far.pulse(9'h100);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h01);
    chk_irq(8'h00);
    wr(icf_pkg::ADDR_CORE_CTRL, 8'h03);
    chk_irq(icf_pkg::VEC_HIGH);
    // second reset in mid-run with state left behind
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      cmp(v, RV[a]);
    end
    cmp(pu, 8'h00);
    final_report();
  end
endmodule
